// file: logic/pic_map.svh
// Constants for the priority interrupt controller
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
`define PIC_NUM_SRC     28
`define PIC_NUM_VEC     10
`define PIC_VEC_BASE    20'h00003
`define PIC_VEC_STEP    20'h00008
`define PIC_VEC_SHARED  4'h3
`endif

// file: logic/pic_pkg.sv
// Types for the priority interrupt controller
`default_nettype none
package pic_pkg;
   // Priority level, ordered so numeric compare ranks them
   typedef enum logic [1:0] {
      PIC_LVL_NONE,
      PIC_LVL_LOW,
      PIC_LVL_HIGH,
      PIC_LVL_TOP
   } pic_level_t;
   // Standby mode the core is in
   typedef enum logic [1:0] {
      PIC_RUN,
      PIC_HALT,
      PIC_HOLD,
      PIC_XHOLD
   } pic_standby_t;
   // Vector grant toward the core
   typedef struct packed {
      logic       valid;
      logic [3:0] index;
      logic [19:0] addr;
      pic_level_t level;
   } pic_grant_t;
endpackage
`default_nettype wire

// file: logic/pic_sync.sv
// Two-flop synchroniser bank for pin inputs
`default_nettype none
module pic_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   // First stage feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule
`default_nettype wire

// file: logic/pic_top.sv
// Priority interrupt controller with nesting and standby wake logic
`default_nettype none
`include "pic_map.svh"
// Contract
// RQ1: Three levels low, high, highest; preemption only by a strictly higher level.
// RQ2: Requests at or below the in-service level are refused.
// RQ3: Simultaneous pending vectors: highest level granted first.
// RQ4: Equal level: smallest vector address wins.
// RQ5: Highest outranks high, high outranks low everywhere.
// RQ6: 28 sources OR onto 10 vectors.
// RQ7: Vector 0001BH shares pins d and f, both base timers, calendar.
// RQ8: Per-vector list of source flags that caused the branch.
// RQ9: Halt ends on reset pin, watchdog reset, or accepted interrupt.
// RQ10: Hold ends on reset, watchdog, pins a-f, port zero, SPI byte.
// RQ11: Crystal hold adds base timer and calendar wake.
// RQ12: Sources stay pending until granted and cleared; one vector at a time.
module pic_top
   import pic_pkg::*;
#(
   parameter int NSRC = `PIC_NUM_SRC,
   parameter int NVEC = `PIC_NUM_VEC
) (
   // Clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   // Source requests, pulse or level, same clock
   input  wire logic [NSRC-1:0]       src_req_i,
   // Software flag clear, one bit per source
   input  wire logic [NSRC-1:0]       src_clr_i,
   // Per-vector level: 1 selects the upper level of the vector
   input  wire logic [NVEC-1:0]       vec_hi_sel_i,
   // External pins a to f, asynchronous, active at specified level high
   input  wire logic [5:0]            ext_irq_pin_i,
   // Core handshake
   input  wire logic                  core_ack_i,
   input  wire logic                  core_ret_i,
   input  wire pic_standby_t          standby_i,
   input  wire logic                  reset_pin_n_i,
   input  wire logic                  wdt_reset_i,
   // Outputs to the core
   output var  pic_grant_t            grant_o,
   output var  pic_level_t            service_level_o,
   output var  logic [NSRC-1:0]       vector_source_flag_list_o,
   output var  logic                  wake_o,
   output var  logic [5:0]            ext_irq_pin_sync_o
);
   // Source index layout; pins a-f are 0..5
   localparam int S_A = 0, S_B = 1, S_C = 2, S_D = 3, S_E = 4, S_F = 5;
   localparam int S_T0L = 6, S_BT0 = 7, S_BT1 = 8, S_RTC = 9, S_T0H = 10;
   localparam int S_SPI = 23, S_PORT0 = 24;

   logic [5:0]       pin_sync;
   logic [NSRC-1:0]  pend;
   logic [NVEC-1:0]  vec_req;
   pic_level_t       lvl_stack [3];
   logic [1:0]       depth;
   logic             ack_q;
   logic [NSRC-1:0]  next_pend;
   pic_level_t       cur_lvl;
   logic             cand_v;
   logic [3:0]       cand_idx;
   pic_level_t       cand_lvl;
   logic             rst_pin_low;

   pic_sync #(.WIDTH(6)) u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (ext_irq_pin_i),
      .sync_o    (pin_sync)
   );

   // Reset pin synchronised inverted, so the flop reset value reads as released
   pic_sync #(.WIDTH(1)) u_rst_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (~reset_pin_n_i),
      .sync_o    (rst_pin_low)
   );

   // Vector to source mask
   function automatic logic [NSRC-1:0] vec_mask(input logic [3:0] v);
      logic [NSRC-1:0] m;
      m = '0;
      case (v)
         4'h0: m[S_A] = 1'b1;
         4'h1: m[S_B] = 1'b1;
         4'h2: begin
            m[S_C]   = 1'b1;
            m[S_E]   = 1'b1;
            m[S_T0L] = 1'b1;
         end
         4'h3: begin // RQ7
            m[S_D]   = 1'b1;
            m[S_F]   = 1'b1;
            m[S_BT0] = 1'b1;
            m[S_BT1] = 1'b1;
            m[S_RTC] = 1'b1;
         end
         4'h4: m[S_T0H] = 1'b1;
         4'h5: m[12:11] = 2'h3;
         4'h6: m[15:13] = 3'h7;
         4'h7: m[18:16] = 3'h7;
         4'h8: m[23:19] = 5'h1f;
         default: m[27:24] = 4'hf;
      endcase
      return m;
   endfunction

   // Level of a vector from its select bit
   function automatic pic_level_t vec_level(input logic [3:0] v, input logic hi);
      if (!hi) begin
         return PIC_LVL_LOW;
      end else if (v < 4'h2) begin
         return PIC_LVL_TOP;
      end else begin
         return PIC_LVL_HIGH;
      end
   endfunction

   // Pins folded into the source requests
   logic [NSRC-1:0] raw_req;
   always_comb begin
      raw_req = src_req_i;
      raw_req[5:0] = src_req_i[5:0] | pin_sync;
   end

   // Shared vectors are the OR of their sources
   always_comb begin
      for (int v = 0; v < NVEC; v++) begin
         vec_req[v] = |(pend & vec_mask(4'(v))); // RQ6
      end
   end

   assign cur_lvl = (depth == 2'd0) ? PIC_LVL_NONE : lvl_stack[depth - 2'd1];

   // Arbiter: level first, then lowest vector
   always_comb begin
      cand_v   = 1'b0;
      cand_idx = 4'h0;
      cand_lvl = PIC_LVL_NONE;
      for (int v = 0; v < NVEC; v++) begin
         if (vec_req[v] && vec_level(4'(v), vec_hi_sel_i[v]) > cand_lvl) begin // RQ3 RQ4 RQ5
            cand_v   = 1'b1;
            cand_idx = 4'(v);
            cand_lvl = vec_level(4'(v), vec_hi_sel_i[v]);
         end
      end
      if (cand_lvl <= cur_lvl) begin // RQ1 RQ2
         cand_v = 1'b0;
      end
   end

   // Pending flags; set wins over clear
   always_comb begin
      next_pend = (pend & ~src_clr_i) | raw_req; // RQ12
   end
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pend <= '0;
      end else begin
         pend <= next_pend;
      end
   end

   // Grant register, one vector at a time
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         grant_o <= '0;
      end else if (grant_o.valid && core_ack_i) begin
         grant_o <= '0;
      end else if (!grant_o.valid || cand_lvl > grant_o.level) begin
         grant_o.valid <= cand_v; // RQ12
         grant_o.index <= cand_idx;
         grant_o.addr  <= `PIC_VEC_BASE + 20'(cand_idx) * `PIC_VEC_STEP;
         grant_o.level <= cand_v ? cand_lvl : PIC_LVL_NONE;
      end
   end

   // Nesting stack of in-service levels
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         depth <= 2'd0;
         for (int i = 0; i < 3; i++) begin
            lvl_stack[i] <= PIC_LVL_NONE;
         end
      end else if (grant_o.valid && core_ack_i && depth < 2'd3) begin
         lvl_stack[depth] <= grant_o.level; // RQ1
         depth <= depth + 2'd1;
      end else if (core_ret_i && depth != 2'd0) begin
         depth <= depth - 2'd1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         service_level_o <= PIC_LVL_NONE;
      end else begin
         service_level_o <= cur_lvl;
      end
   end

   // Source flag list latched at vector acceptance
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         vector_source_flag_list_o <= '0;
      end else if (grant_o.valid && core_ack_i) begin
         vector_source_flag_list_o <= pend & vec_mask(grant_o.index); // RQ8
      end
   end

   // Standby wake conditions
   logic hold_wake;
   logic xhold_wake;
   logic wake_c;
   assign hold_wake  = (|pin_sync) | pend[S_PORT0] | pend[S_SPI]; // RQ10
   assign xhold_wake = hold_wake | pend[S_BT0] | pend[S_BT1] | pend[S_RTC]; // RQ11
   always_comb begin
      wake_c = rst_pin_low || wdt_reset_i;
      case (standby_i)
         PIC_HALT:  wake_c = wake_c || cand_v; // RQ9
         PIC_HOLD:  wake_c = wake_c || hold_wake;
         PIC_XHOLD: wake_c = wake_c || xhold_wake;
         default:   wake_c = 1'b0;
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wake_o <= 1'b0;
         ext_irq_pin_sync_o <= '0;
         ack_q <= 1'b0;
      end else begin
         wake_o <= wake_c;
         ext_irq_pin_sync_o <= pin_sync;
         ack_q <= grant_o.valid && core_ack_i;
      end
   end

   // Grant only above the level in service
   grant_above_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ2
      $rose(grant_o.valid) |-> grant_o.level > service_level_o || depth == 2'd0)
      else $error("grant not above service level");
   // Vector address derived from index
   vec_addr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ6
      grant_o.valid |-> grant_o.addr == `PIC_VEC_BASE + 20'(grant_o.index) * `PIC_VEC_STEP)
      else $error("vector address mismatch");
   // Pending sticks until cleared
   pend_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ12
      pend[S_A] && !src_clr_i[S_A] |=> pend[S_A])
      else $error("pending flag lost");
   // Acceptance raises nesting depth
   nest_push_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ1
      grant_o.valid && core_ack_i && depth < 2'd3 && !core_ret_i
      |=> depth == $past(depth) + 2'd1)
      else $error("depth did not grow");
   // Halt wakes one cycle after a candidate
   halt_wake_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ9
      standby_i == PIC_HALT && cand_v |=> wake_o)
      else $error("halt not woken");
   // Hold wakes on port zero
   hold_wake_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ10
      standby_i == PIC_HOLD && pend[S_PORT0] |=> wake_o)
      else $error("hold not woken");
   // Crystal hold wakes on calendar
   xhold_wake_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ11
      standby_i == PIC_XHOLD && pend[S_RTC] |=> wake_o)
      else $error("crystal hold not woken");
   // Flag list only holds sources of the granted vector
   flag_list_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ8
      ack_q |-> (vector_source_flag_list_o & ~vec_mask($past(grant_o.index))) == '0)
      else $error("flag list outside vector");
   // Top vector 0 beats higher vector of lower level
   level_order_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ3 RQ5
      cand_v && vec_req[0] && vec_hi_sel_i[0] |-> cand_idx == 4'h0)
      else $error("highest level not chosen");
   // At low level, lowest requesting vector wins
   low_addr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ4
      cand_v && cand_lvl == PIC_LVL_LOW
      |-> (vec_req & ((10'h1 << cand_idx) - 10'h1)) == '0)
      else $error("lower vector skipped");
endmodule
`default_nettype wire

// file: verification/pic_core_model.sv
// Behavioural core that acknowledges vector grants
`default_nettype none
module pic_core_model
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   // Grant and answer delay
   input  wire pic_grant_t grant_i,
   input  wire logic [3:0] wait_i,
   // Acknowledge pulse
   output var  logic       ack_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt;
   // One-cycle ack once a grant has stood wait_i+1 cycles
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || ack_o || grant_i.valid !== 1'b1) begin
         ack_o <= 1'b0;
         cnt   <= 4'h0;
      end else if (cnt >= wait_i) begin
         ack_o <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: verification/tb_pic_top.sv
// Bench for the priority interrupt controller
`default_nettype none
`include "pic_map.svh"
module tb_pic_top
   import pic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Stimulus and observed outputs
   logic         ref_clk_i = 1'b0;
   logic         sys_rst_i = 1'b1;
   logic [27:0]  src_req_i = '0;
   logic [27:0]  src_clr_i = '0;
   logic [9:0]   vec_hi_sel_i = '0;
   logic [5:0]   ext_irq_pin_i = '0;
   logic         core_ret_i = 1'b0;
   logic         reset_pin_n_i = 1'b1;
   logic         wdt_reset_i = 1'b0;
   pic_standby_t standby_i = PIC_RUN;
   logic [3:0]   ack_wait = 4'h0;
   logic         core_ack_i;
   pic_grant_t   grant_o;
   pic_level_t   service_level_o;
   logic [27:0]  flags;
   logic         wake_o;
   logic [5:0]   pins_seen;
   int           fail_count = 0;
   int           checks_done = 0;
   int           cycles = 0;
   // Controller and core model
   pic_top u_pic_top (.ref_clk_i, .sys_rst_i, .src_req_i, .src_clr_i, .vec_hi_sel_i,
      .ext_irq_pin_i, .core_ack_i, .core_ret_i, .standby_i, .reset_pin_n_i,
      .wdt_reset_i, .grant_o, .service_level_o, .vector_source_flag_list_o(flags),
      .wake_o, .ext_irq_pin_sync_o(pins_seen));
   pic_core_model u_pic_core_model (.ref_clk_i, .sys_rst_i, .grant_i(grant_o),
      .wait_i(ack_wait), .ack_o(core_ack_i));
   // Clock and hang guard
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // Vector that each source shares
   function automatic logic [3:0] vec_of(input int s);
      if (s < 2) return 4'(s);
      if (s == 2 || s == 4 || s == 6) return 4'h2;
      if (s < 10) return 4'h3;
      if (s == 10) return 4'h4;
      if (s < 13) return 4'h5;
      if (s < 16) return 4'h6;
      if (s < 19) return 4'h7;
      return (s < 24) ? 4'h8 : 4'h9;
   endfunction
   task automatic req(input int s);
      src_req_i[s] = 1'b1;
      tick();
      src_req_i[s] = 1'b0;
   endtask
   task automatic serve(input int s, input pic_level_t lvl);
      logic [3:0] v;
      int         n;
      v = vec_of(s);
      n = 0;
      while (grant_o.valid !== 1'b1 && n < 40) begin
         tick();
         n++;
      end
      chk(grant_o.index, v);
      chk(grant_o.addr, `PIC_VEC_BASE + `PIC_VEC_STEP * v);
      chk(grant_o.level, lvl);
      while (core_ack_i !== 1'b1 && n < 80) begin
         tick();
         n++;
      end
      tick(2);
      chk(flags, 28'h1 << s);
      chk(service_level_o, lvl);
   endtask
   task automatic fin(input int s);
      src_clr_i[s] = 1'b1;
      tick();
      src_clr_i[s] = 1'b0;
      core_ret_i = 1'b1;
      tick();
      core_ret_i = 1'b0;
   endtask
   task automatic t_each();
      for (int s = 0; s < 28; s++) begin
         req(s);
         serve(s, PIC_LVL_LOW);
         fin(s);
      end
      $display("t_each done");
   endtask
   task automatic t_same();
      vec_hi_sel_i = 10'h020;
      src_req_i = 28'h8100800;
      tick();
      src_req_i = '0;
      serve(11, PIC_LVL_HIGH);
      fin(11);
      serve(20, PIC_LVL_LOW);
      fin(20);
      serve(27, PIC_LVL_LOW);
      fin(27);
      $display("t_same done");
   endtask
   task automatic t_nest();
      int n;
      ack_wait = 4'h3;
      vec_hi_sel_i = 10'h023;
      req(27);
      serve(27, PIC_LVL_LOW);
      req(0);
      serve(0, PIC_LVL_TOP);
      src_req_i = 28'h0000802;
      tick();
      src_req_i = '0;
      n = 0;
      repeat (8) begin
         tick();
         if (grant_o.valid !== 1'b0) n++;
      end
      chk(n, 0);
      fin(0);
      serve(1, PIC_LVL_TOP);
      fin(1);
      serve(11, PIC_LVL_HIGH);
      fin(11);
      fin(27);
      ack_wait = 4'h0;
      vec_hi_sel_i = '0;
      $display("t_nest done");
   endtask
   // Codes 90-95 raise a pin, 98 watchdog, 99 reset pin
   task automatic wk(input pic_standby_t m, input int s, input logic e);
      int n;
      standby_i = m;
      tick();
      if (s == 99) reset_pin_n_i = 1'b0;
      else if (s == 98) wdt_reset_i = 1'b1;
      else if (s >= 90) ext_irq_pin_i[s-90] = 1'b1;
      else src_req_i[s] = 1'b1;
      tick();
      src_req_i = '0;
      n = 0;
      while (wake_o !== 1'b1 && n < 12) begin
         tick();
         n++;
      end
      chk(wake_o, e);
      if (s >= 90 && s < 96) chk(pins_seen, 6'h1 << (s - 90));
      reset_pin_n_i = 1'b1;
      wdt_reset_i = 1'b0;
      ext_irq_pin_i = '0;
      standby_i = PIC_RUN;
      tick(3);
      if (s < 96) fin(s % 90);
   endtask
   task automatic t_wake();
      wk(PIC_HALT, 10, 1'b1);
      wk(PIC_HALT, 99, 1'b1);
      wk(PIC_HALT, 98, 1'b1);
      wk(PIC_HOLD, 9, 1'b0);
      wk(PIC_HOLD, 93, 1'b1);
      wk(PIC_HOLD, 23, 1'b1);
      wk(PIC_HOLD, 24, 1'b1);
      wk(PIC_XHOLD, 9, 1'b1);
      wk(PIC_XHOLD, 7, 1'b1);
      wk(PIC_XHOLD, 10, 1'b0);
      wk(PIC_XHOLD, 95, 1'b1);
      wk(PIC_XHOLD, 99, 1'b1);
      wk(PIC_HOLD, 98, 1'b1);
      wk(PIC_RUN, 10, 1'b0);
      $display("t_wake done");
   endtask
   // Reset, then the scenarios
   initial begin
      repeat (20) @(posedge ref_clk_i);
      #1 sys_rst_i = 1'b0;
      tick(3);
      t_each();
      t_same();
      t_nest();
      t_wake();
      tally_and_finish();
   end
endmodule
`default_nettype wire
